// file: design/esp_pkg.sv
// package of constants and types for the exception state and priority unit
//
// Summary of operation
// RULE_01 - each exception: inactive, pending, active, both
// RULE_02 - peripheral or software request makes interrupt pending
// RULE_03 - nested handlers all stay marked active
// RULE_04 - new request while active gives active-and-pending
// RULE_05 - reset halts; restart privileged thread at vector
// RULE_06 - reset, NMI, hard fault fixed -3,-2,-1
// RULE_07 - NMI always enabled, only reset preempts
// RULE_08 - hard fault on entry error or unhandleable fault
// RULE_09 - memory management fault synchronous on protection violation
// RULE_10 - bus fault: precise synchronous, imprecise asynchronous
// RULE_11 - usage fault for undefined, unaligned, state, return
// RULE_12 - optional usage fault: unaligned access, divide zero
// RULE_13 - supervisor call synchronous, number 11, configurable
// RULE_14 - deferred service request asynchronous, number 14
// RULE_15 - system tick on timer zero or software
// RULE_16 - all interrupts are asynchronous
// RULE_17 - numbers 1-6 fixed; 7-10, 12-13 reserved
// RULE_18 - asynchronous entry may follow one more instruction
// RULE_19 - configurable-priority exceptions can be disabled
// RULE_20 - entry clears local and global exclusive tags; the code clears global tags only when i_mp_system is set
// RULE_21 - lower value more urgent; 0-15, default 0
// RULE_22 - equal priority: lowest exception number first
// RULE_23 - equal priority never preempts, only pends
// RULE_24 - present best enabled pending exception as candidate
package esp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_EXC = 32;
  localparam int NUM_IRQ = 16;
  localparam int EXC_W   = 5;
  localparam int PRIO_W  = 4;
  localparam int EPRIO_W = 5;

  // ----------------------------------------------------------------
  // exception numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] EXC_RESET    = 5'h01;
  localparam logic [4:0] EXC_NMI      = 5'h02;
  localparam logic [4:0] EXC_HARD     = 5'h03;
  localparam logic [4:0] EXC_MEM      = 5'h04;
  localparam logic [4:0] EXC_BUS      = 5'h05;
  localparam logic [4:0] EXC_USAGE    = 5'h06;
  localparam logic [4:0] EXC_SVC      = 5'h0B;
  localparam logic [4:0] EXC_DEFER    = 5'h0E;
  localparam logic [4:0] EXC_SYSTICK  = 5'h0F;
  localparam int         IRQ_BASE     = 16;

  // ----------------------------------------------------------------
  // vectors: offset is exception number times four
  // ----------------------------------------------------------------
  localparam logic [31:0] VEC_RESET   = 32'h00000004;
  localparam int          VEC_SHIFT   = 2;

  // ----------------------------------------------------------------
  // effective priority: fixed ones below every configurable value
  // ----------------------------------------------------------------
  localparam logic [4:0] EPRIO_RESET  = 5'h00;
  localparam logic [4:0] EPRIO_NMI    = 5'h01;
  localparam logic [4:0] EPRIO_HARD   = 5'h02;
  localparam logic [4:0] EPRIO_CFG    = 5'h03;
  localparam logic [4:0] EPRIO_IDLE   = 5'h1F;
  localparam logic [3:0] PRIO_RESET   = 4'h0;

  // ----------------------------------------------------------------
  // masks over exception numbers
  // ----------------------------------------------------------------
  localparam logic [31:0] IMPL_MASK   = 32'hFFFFC87E;
  localparam logic [31:0] FIXED_MASK  = 32'h0000000E;
  localparam logic [31:0] SYNC_MASK   = 32'h00000850;

  typedef logic [3:0] esp_prio_t;

  typedef enum logic [3:0] {
    ESP_INACTIVE = 4'h1,
    ESP_PENDING  = 4'h2,
    ESP_ACTIVE   = 4'h4,
    ESP_ACT_PEND = 4'h8
  } esp_exc_state_e;

  typedef enum logic [1:0] {
    ESP_HALTED  = 2'h1,
    ESP_RUNNING = 2'h2
  } esp_core_e;

  typedef struct packed {
    logic        valid;
    logic [4:0]  num;
    logic [4:0]  eprio;
    logic        sync;
    logic [31:0] vec;
  } esp_cand_s;

  typedef struct packed {
    logic undef_instr;
    logic unaligned_illegal;
    logic bad_state;
    logic exc_return_err;
    logic unaligned_access;
    logic div_by_zero;
  } esp_usage_s;

endpackage : esp_pkg

// file: design/esp_arbiter.sv
// priority pick: most urgent request, lowest number on a tie
`timescale 1ns/100ps
`default_nettype none
module esp_arbiter (
  input  wire logic [31:0]      i_req,    // requesting exceptions
  input  wire logic [31:0][4:0] i_eprio,  // effective priority per number
  output logic                  o_valid,  // some request present
  output logic [4:0]            o_num,    // winning number
  output logic [4:0]            o_eprio   // winning priority
);

  // descending scan with <= lets the lower number win ties
  always_comb begin
    o_valid = 1'b0;
    o_num   = 5'h00;
    o_eprio = esp_pkg::EPRIO_IDLE;
    for (int i = esp_pkg::NUM_EXC - 1; i >= 0; i--) begin
      if (i_req[i] && (i_eprio[i] <= o_eprio)) begin  // RULE_21 RULE_22
        o_valid = 1'b1;
        o_num   = 5'(i);
        o_eprio = i_eprio[i];
      end
    end
  end

endmodule : esp_arbiter
`default_nettype wire

// file: design/esp_unit.sv
// exception state tracking, escalation and priority selection
`timescale 1ns/100ps
`default_nettype none
module esp_unit (
  input  wire logic                   i_clk,             // core clock
  input  wire logic                   i_rst_b,           // sync reset, low
  input  wire logic [15:0]            i_irq,             // peripheral lines
  input  wire logic [15:0]            i_irq_swset,       // software pend pulse
  input  wire logic                   i_nmi,             // NMI pin
  input  wire logic                   i_nmi_sw,          // software NMI pulse
  input  wire logic                   i_systick_zero,    // timer reached zero
  input  wire logic                   i_systick_sw,      // software tick pulse
  input  wire logic                   i_defer_set,       // deferred request
  input  wire logic                   i_svc_exec,        // supervisor call
  input  wire logic                   i_mm_fault,        // protection violation
  input  wire logic                   i_xn_fetch,        // execute-never fetch
  input  wire logic                   i_bus_err_precise, // precise bus error
  input  wire logic                   i_bus_err_imprec,  // imprecise bus error
  input  wire esp_pkg::esp_usage_s    i_usage,           // usage fault causes
  input  wire logic                   i_unalign_trap_en, // report unaligned
  input  wire logic                   i_div0_trap_en,    // report div by zero
  input  wire logic                   i_entry_err,       // error during entry
  input  wire logic [31:0]            i_enable,          // per-number enables
  input  wire esp_pkg::esp_prio_t [31:0] i_prio,         // configured priority
  input  wire logic                   i_mp_system,       // multiprocessor
  input  wire logic                   i_entry,           // pipeline takes cand
  input  wire logic                   i_exc_return,      // handler returns
  input  wire logic [4:0]             i_ret_num,         // returning number
  output esp_pkg::esp_cand_s          o_cand,            // entry candidate
  output logic                        o_preempt,         // candidate may enter
  output logic [31:0]                 o_pending,         // pending bits
  output logic [31:0]                 o_active,          // active bits
  output esp_pkg::esp_exc_state_e [31:0] o_exc_state,    // per-number state
  output logic                        o_halt,            // core stopped
  output logic                        o_restart,         // restart pulse
  output logic [31:0]                 o_restart_vec,     // restart vector slot
  output logic                        o_priv_thread,     // privileged thread
  output logic                        o_clr_local_excl,  // clear local tag
  output logic                        o_clr_global_excl  // clear global tags
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] eff_prio(input int num, input esp_pkg::esp_prio_t p);
    logic [4:0] r;
    r = esp_pkg::EPRIO_CFG + {1'b0, p};
    if (num == int'(esp_pkg::EXC_RESET)) r = esp_pkg::EPRIO_RESET;  // RULE_06
    if (num == int'(esp_pkg::EXC_NMI))   r = esp_pkg::EPRIO_NMI;    // RULE_06
    if (num == int'(esp_pkg::EXC_HARD))  r = esp_pkg::EPRIO_HARD;   // RULE_06
    return r;
  endfunction : eff_prio

  function automatic esp_pkg::esp_exc_state_e state_of(input logic pend, input logic act);
    esp_pkg::esp_exc_state_e s;
    s = esp_pkg::ESP_INACTIVE;
    if (pend && !act) s = esp_pkg::ESP_PENDING;
    if (!pend && act) s = esp_pkg::ESP_ACTIVE;
    if (pend && act)  s = esp_pkg::ESP_ACT_PEND;
    return s;
  endfunction : state_of

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]             pend_r;
  logic [31:0]             pend_nxt;
  logic [31:0]             act_r;
  logic [31:0]             act_nxt;
  logic [15:0]             irq_s1_r;
  logic [15:0]             irq_s2_r;
  logic [15:0]             irq_prev_r;
  logic                    nmi_s1_r;
  logic                    nmi_s2_r;
  logic                    nmi_prev_r;
  logic                    bus_sync_r;
  esp_pkg::esp_core_e      core_r;
  esp_pkg::esp_cand_s      cand_r;
  logic [31:0][4:0]        eprio;
  logic [31:0]             en_all;
  logic [31:0]             set_v;
  logic [31:0]             entry_oh;
  logic [31:0]             ret_oh;
  logic                    usage_any;
  logic                    run_valid;
  logic [4:0]              run_eprio;
  logic                    arb_valid;
  logic [4:0]              arb_num;
  logic [4:0]              arb_eprio;
  logic                    esc_mem;
  logic                    esc_bus;
  logic                    esc_usage;
  logic                    esc_svc;
  logic                    take;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // peripheral lines and the NMI pin come from other domains
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      irq_s1_r   <= 16'h0000;
      irq_s2_r   <= 16'h0000;
      irq_prev_r <= 16'h0000;
      nmi_s1_r   <= 1'b0;
      nmi_s2_r   <= 1'b0;
      nmi_prev_r <= 1'b0;
    end else begin
      irq_s1_r   <= i_irq;
      irq_s2_r   <= irq_s1_r;
      irq_prev_r <= irq_s2_r;
      nmi_s1_r   <= i_nmi;
      nmi_s2_r   <= nmi_s1_r;
      nmi_prev_r <= nmi_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // priorities and enables
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < esp_pkg::NUM_EXC; g++) begin : g_prio
      assign eprio[g]       = eff_prio(g, i_prio[g]);  // RULE_21
      assign o_exc_state[g] = state_of(pend_r[g], act_r[g]);  // RULE_01
    end
  endgenerate

  // fixed ones are always on; reserved numbers never participate
  assign en_all = (i_enable | esp_pkg::FIXED_MASK) & esp_pkg::IMPL_MASK;  // RULE_07 RULE_19 RULE_17

  esp_arbiter u_run_arb (
    .i_req   (act_r),
    .i_eprio (eprio),
    .o_valid (run_valid),
    .o_num   (),
    .o_eprio (run_eprio)
  );

  // ----------------------------------------------------------------
  // event collection and escalation
  // ----------------------------------------------------------------
  assign usage_any = i_usage.undef_instr | i_usage.unaligned_illegal
                   | i_usage.bad_state | i_usage.exc_return_err  // RULE_11
                   | (i_usage.unaligned_access & i_unalign_trap_en)  // RULE_12
                   | (i_usage.div_by_zero & i_div0_trap_en);  // RULE_12

  // a synchronous fault that is disabled or cannot preempt now is
  // unhandleable and escalates; waiting would stall the faulting code
  assign esc_mem   = (i_mm_fault | i_xn_fetch) &
                     (!en_all[esp_pkg::EXC_MEM] || eprio[esp_pkg::EXC_MEM] >= run_eprio);
  assign esc_bus   = i_bus_err_precise &
                     (!en_all[esp_pkg::EXC_BUS] || eprio[esp_pkg::EXC_BUS] >= run_eprio);
  assign esc_usage = usage_any &
                     (!en_all[esp_pkg::EXC_USAGE] || eprio[esp_pkg::EXC_USAGE] >= run_eprio);
  assign esc_svc   = i_svc_exec &
                     (!en_all[esp_pkg::EXC_SVC] || eprio[esp_pkg::EXC_SVC] >= run_eprio);

  always_comb begin
    set_v                       = 32'h00000000;
    set_v[31:16]                = (irq_s2_r & ~irq_prev_r) | i_irq_swset;  // RULE_02 RULE_16
    set_v[esp_pkg::EXC_NMI]     = (nmi_s2_r & ~nmi_prev_r) | i_nmi_sw;
    set_v[esp_pkg::EXC_HARD]    = i_entry_err | esc_mem | esc_bus | esc_usage | esc_svc;  // RULE_08
    set_v[esp_pkg::EXC_MEM]     = (i_mm_fault | i_xn_fetch) & ~esc_mem;  // RULE_09
    set_v[esp_pkg::EXC_BUS]     = (i_bus_err_precise & ~esc_bus) | i_bus_err_imprec;  // RULE_10
    set_v[esp_pkg::EXC_USAGE]   = usage_any & ~esc_usage;  // RULE_11
    set_v[esp_pkg::EXC_SVC]     = i_svc_exec & ~esc_svc;  // RULE_13
    set_v[esp_pkg::EXC_DEFER]   = i_defer_set;  // RULE_14
    set_v[esp_pkg::EXC_SYSTICK] = i_systick_zero | i_systick_sw;  // RULE_15
    set_v                       = set_v & esp_pkg::IMPL_MASK;  // RULE_17
  end

  // ----------------------------------------------------------------
  // pending and active bookkeeping
  // ----------------------------------------------------------------
  assign take     = i_entry && cand_r.valid;
  assign entry_oh = take ? (32'h00000001 << cand_r.num) : 32'h00000000;
  assign ret_oh   = i_exc_return ? (32'h00000001 << i_ret_num) : 32'h00000000;

  // a request in the cycle of its own entry stays pending
  assign pend_nxt = (pend_r & ~entry_oh) | set_v;  // RULE_02 RULE_04
  // return before entry so a tail-chained re-entry stays active
  assign act_nxt  = (act_r & ~ret_oh) | entry_oh;  // RULE_03

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_r <= 32'h00000000;
      act_r  <= 32'h00000000;
    end else begin
      pend_r <= pend_nxt;  // RULE_04
      act_r  <= act_nxt;  // RULE_03
    end
  end

  // remember whether the latest bus fault was precise
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus_sync_r <= 1'b0;
    end else if (i_bus_err_precise || i_bus_err_imprec) begin
      bus_sync_r <= i_bus_err_precise;  // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // candidate selection
  // ----------------------------------------------------------------
  // the entered one is masked so the candidate is not offered twice
  esp_arbiter u_cand_arb (
    .i_req   (pend_r & en_all & ~entry_oh),
    .i_eprio (eprio),
    .o_valid (arb_valid),
    .o_num   (arb_num),
    .o_eprio (arb_eprio)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cand_r <= '0;
    end else begin
      cand_r.valid <= arb_valid;  // RULE_24
      cand_r.num   <= arb_num;
      cand_r.eprio <= arb_eprio;
      // asynchronous candidates let the pipeline finish one instruction
      cand_r.sync  <= esp_pkg::SYNC_MASK[arb_num] |
                      ((arb_num == esp_pkg::EXC_BUS) & bus_sync_r);  // RULE_18 RULE_16
      cand_r.vec   <= 32'({arb_num, 2'b00});
    end
  end

  assign o_cand    = cand_r;
  // strict compare: equal priority only pends, never preempts
  assign o_preempt = cand_r.valid && (cand_r.eprio < run_eprio);  // RULE_23 RULE_07
  assign o_pending = pend_r;
  assign o_active  = act_r;

  // ----------------------------------------------------------------
  // reset handling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      core_r        <= esp_pkg::ESP_HALTED;
      o_restart     <= 1'b0;
      o_restart_vec <= 32'h00000000;
      o_priv_thread <= 1'b0;
    end else begin
      o_restart <= 1'b0;
      unique case (core_r)
        esp_pkg::ESP_HALTED: begin
          core_r        <= esp_pkg::ESP_RUNNING;
          o_restart     <= 1'b1;  // RULE_05
          o_restart_vec <= esp_pkg::VEC_RESET;  // RULE_05
          o_priv_thread <= 1'b1;  // RULE_05
        end
        esp_pkg::ESP_RUNNING: begin
          core_r <= esp_pkg::ESP_RUNNING;
        end
        default: begin
          core_r <= esp_pkg::ESP_HALTED;
        end
      endcase
    end
  end

  // stops the core in the very cycle reset is seen
  assign o_halt = !i_rst_b || (core_r == esp_pkg::ESP_HALTED);  // RULE_05

  // ----------------------------------------------------------------
  // exclusive monitor clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_clr_local_excl  <= 1'b0;
      o_clr_global_excl <= 1'b0;
    end else begin
      o_clr_local_excl  <= take;  // RULE_20
      o_clr_global_excl <= take && i_mp_system;  // RULE_20
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_state_onehot;
    $onehot(o_exc_state[esp_pkg::EXC_NMI]) && $onehot(o_exc_state[esp_pkg::IRQ_BASE]);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("state not one-hot"); // RULE_01

  property p_sw_pend;
    (i_irq_swset != 16'h0000) |=> ((pend_r[31:16] & $past(i_irq_swset)) == $past(i_irq_swset));
  endproperty
  a_sw_pend: assert property (p_sw_pend) else $error("software request not pending"); // RULE_02

  property p_nest;
    (take && act_r != 32'h00000000 && !i_exc_return)
      |=> (((act_r & $past(act_r)) == $past(act_r)) && act_r[$past(cand_r.num)]);
  endproperty
  a_nest: assert property (p_nest) else $error("nested handler lost active"); // RULE_03

  property p_act_pend;
    ((i_irq_swset & act_r[31:16]) != 16'h0000) && !i_exc_return
      |=> ((pend_r[31:16] & act_r[31:16] & $past(i_irq_swset)) != 16'h0000);
  endproperty
  a_act_pend: assert property (p_act_pend) else $error("no active and pending"); // RULE_04

  property p_restart;
    (core_r == esp_pkg::ESP_HALTED)
      |=> (o_restart && o_priv_thread && o_restart_vec == esp_pkg::VEC_RESET) ##1 !o_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart after reset"); // RULE_05

  property p_hard_first;
    (pend_r[esp_pkg::EXC_HARD] && !pend_r[esp_pkg::EXC_NMI] && !take)
      |=> (cand_r.valid && cand_r.num == esp_pkg::EXC_HARD);
  endproperty
  a_hard_first: assert property (p_hard_first) else $error("hard fault not chosen"); // RULE_06

  property p_nmi_first;
    (pend_r[esp_pkg::EXC_NMI] && !(take && cand_r.num == esp_pkg::EXC_NMI))
      |=> (cand_r.num == esp_pkg::EXC_NMI && cand_r.eprio == esp_pkg::EPRIO_NMI);
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("NMI not chosen"); // RULE_07

  property p_svc_raise;
    i_svc_exec |=> (pend_r[esp_pkg::EXC_SVC] || pend_r[esp_pkg::EXC_HARD]);
  endproperty
  a_svc_raise: assert property (p_svc_raise) else $error("supervisor call lost"); // RULE_13

  property p_excl_clear;
    take |=> (o_clr_local_excl && (o_clr_global_excl == $past(i_mp_system)));
  endproperty
  a_excl_clear: assert property (p_excl_clear) else $error("exclusive tag not cleared"); // RULE_20

  property p_no_equal_preempt;
    (cand_r.valid && run_valid && cand_r.eprio >= run_eprio) |-> !o_preempt;
  endproperty
  a_no_equal_preempt: assert property (p_no_equal_preempt) else $error("equal priority preempted"); // RULE_23

  localparam int IRQ_BASE_C = esp_pkg::IRQ_BASE;
  c_nested: cover property (take && act_r != 32'h00000000);
  c_escalate: cover property (esc_mem || esc_usage || esc_svc);
  c_act_pend: cover property (pend_r[IRQ_BASE_C] && act_r[IRQ_BASE_C]);

endmodule : esp_unit
`default_nettype wire

// file: testbench/esp_pipe_model.sv
// pipeline model: enters the offered candidate, promptly or late
`timescale 1ns/100ps
`default_nettype none
module esp_pipe_model (
  input  wire logic               i_clk,     // core clock
  input  wire logic               i_go,      // accept candidates
  input  wire logic [1:0]         i_slow,    // extra wait cycles
  input  wire esp_pkg::esp_cand_s i_cand,    // offered candidate
  input  wire logic               i_preempt, // entry allowed
  output logic                    o_entry    // entry pulse
);
  logic [1:0] wait_r;
  initial begin
    o_entry = 1'b0;
    wait_r  = 2'h0;
  end
  // gap after each entry so the candidate has moved on
  always @(negedge i_clk) begin
    if (i_go && !o_entry && i_cand.valid && i_preempt) begin
      o_entry <= (wait_r >= i_slow);
      wait_r  <= (wait_r < i_slow) ? wait_r + 2'h1 : 2'h0;
    end else begin
      o_entry <= 1'b0;
      wait_r  <= 2'h0;
    end
  end
endmodule : esp_pipe_model
`default_nettype wire

// file: testbench/esp_unit_tb.sv
// self-checking testbench of the exception state and priority unit
`timescale 1ns/100ps
`default_nettype none
module esp_unit_tb;
  logic                           clk, rst_b, nmi, go, mp, ret, div0, entry, preempt;
  logic                           halt, rstrt, priv, clr_l, clr_g;
  logic [1:0]                     slow;
  logic [4:0]                     rnum;
  logic [7:0]                     ev;
  logic [15:0]                    irq, sw;
  logic [31:0]                    en, pend, act, rvec;
  esp_pkg::esp_usage_s            us;
  esp_pkg::esp_prio_t [31:0]      prio;
  esp_pkg::esp_cand_s             cand;
  esp_pkg::esp_exc_state_e [31:0] st;
  int                             failures, num_checks;

  esp_unit dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_irq(irq), .i_irq_swset(sw), .i_nmi(nmi),
    .i_nmi_sw(ev[6]), .i_systick_zero(ev[2]), .i_systick_sw(ev[7]), .i_defer_set(ev[1]),
    .i_svc_exec(ev[0]), .i_mm_fault(ev[3]), .i_xn_fetch(1'b0), .i_bus_err_precise(ev[4]),
    .i_bus_err_imprec(1'b0), .i_usage(us), .i_unalign_trap_en(1'b0), .i_div0_trap_en(div0),
    .i_entry_err(ev[5]), .i_enable(en), .i_prio(prio), .i_mp_system(mp), .i_entry(entry),
    .i_exc_return(ret), .i_ret_num(rnum), .o_cand(cand), .o_preempt(preempt),
    .o_pending(pend), .o_active(act), .o_exc_state(st), .o_halt(halt), .o_restart(rstrt),
    .o_restart_vec(rvec), .o_priv_thread(priv), .o_clr_local_excl(clr_l),
    .o_clr_global_excl(clr_g));
  esp_pipe_model pipe_u (.i_clk(clk), .i_go(go), .i_slow(slow), .i_cand(cand),
    .i_preempt(preempt), .o_entry(entry));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic close_out;
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic pulse(input logic [7:0] e, input logic [15:0] s, input logic [5:0] u);
    ev = e;
    sw = s;
    us = u;
    @(negedge clk);
    ev = 8'h00;
    sw = 16'h0000;
    us = 6'h00;
  endtask : pulse

  // bounded wait for the model to enter exception n
  task automatic enter(input int n, input logic [1:0] s);
    int k;
    slow = s;
    go <= 1'b1;
    for (k = 0; k < 12 && act[n] !== 1'b1; k++) @(negedge clk);
    go <= 1'b0;
    if (k == 12) begin
      failures++;
      close_out();
    end
  endtask : enter

  task automatic t_reset;
    repeat (20) @(negedge clk);
    chk("halt", 32'h1, halt);
    chk("st16", esp_pkg::ESP_INACTIVE, st[16]);
    rst_b = 1'b1;
    @(negedge clk);
    chk("restart", 32'h1, rstrt);
    chk("halt", 32'h0, halt);
    chk("rvec", 32'h00000004, rvec);
    chk("priv", 32'h1, priv);
  endtask : t_reset

  task automatic t_refuse;
    pulse(8'h00, 16'h0002, 6'h01);
    chk("pend17", 32'h1, pend[17]);
    chk("pend6", 32'h0, pend[6]);
    @(negedge clk);
    chk("cvalid", 32'h0, cand.valid);
  endtask : t_refuse

  task automatic t_svc;
    pulse(8'h01, 16'h0000, 6'h00);
    chk("st11", esp_pkg::ESP_PENDING, st[11]);
    @(negedge clk);
    chk("cnum", 32'h0B, cand.num);
    chk("csync", 32'h1, cand.sync);
    chk("cvec", 32'h0000002C, cand.vec);
    chk("cprio", 32'h07, cand.eprio);
    enter(11, 2'h0);
    chk("clr_l", 32'h1, clr_l);
    chk("clr_g", 32'h0, clr_g);
  endtask : t_svc

  task automatic t_pin;
    irq = 16'h0001;
    repeat (5) @(negedge clk);
    chk("st16", esp_pkg::ESP_PENDING, st[16]);
    chk("csync", 32'h0, cand.sync);
    chk("preempt", 32'h0, preempt);
  endtask : t_pin

  task automatic t_nest;
    en[17] = 1'b1;
    mp = 1'b1;
    pulse(8'h02, 16'h0000, 6'h00);
    @(negedge clk);
    chk("cnum", 32'h0E, cand.num);
    chk("cvec", 32'h00000038, cand.vec);
    chk("csync", 32'h0, cand.sync);
    chk("preempt", 32'h1, preempt);
    enter(14, 2'h2);
    chk("act11", 32'h1, act[11]);
    chk("clr_g", 32'h1, clr_g);
  endtask : t_nest

  // disabled usage fault, now reported, has to land on hard fault
  task automatic t_escal;
    div0 = 1'b1;
    pulse(8'h02, 16'h0000, 6'h01);
    chk("pend3", 32'h1, pend[3]);
    chk("st14", esp_pkg::ESP_ACT_PEND, st[14]);
    @(negedge clk);
    chk("cnum", 32'h03, cand.num);
    chk("cprio", 32'h02, cand.eprio);
    nmi = 1'b1;
    repeat (5) @(negedge clk);
    chk("cnum", 32'h02, cand.num);
    chk("cprio", 32'h01, cand.eprio);
  endtask : t_escal

  // faults under a priority-1 handler: more urgent enabled ones pend, disabled usage escalates
  task automatic t_fault;
    pulse(8'h9C, 16'h0000, 6'h20);
    chk("pend4", 32'h1, pend[4]);
    chk("pend5", 32'h1, pend[5]);
    chk("pend15", 32'h1, pend[15]);
    chk("pend6", 32'h0, pend[6]);
    chk("rsvd", 32'h0, pend & ~esp_pkg::IMPL_MASK);
    rnum = 5'h0E;
    ret = 1'b1;
    @(negedge clk);
    ret = 1'b0;
    chk("st14", esp_pkg::ESP_PENDING, st[14]);
    chk("act11", 32'h1, act[11]);
  endtask : t_fault

  initial begin
    failures = 0;
    num_checks = 0;
    {rst_b, nmi, go, mp, ret, div0} = 6'h00;
    {ev, irq, sw, slow, rnum} = 47'h0;
    us = 6'h00;
    en = 32'hFFFDFFBF;
    prio = '0;
    prio[11] = 4'h4;
    prio[14] = 4'h1;
    prio[16] = 4'h4;
    prio[17] = 4'h1;
    t_reset();
    t_refuse();
    t_svc();
    t_pin();
    t_nest();
    t_escal();
    t_fault();
    close_out();
  end
endmodule : esp_unit_tb
`default_nettype wire
